/* cgmc_pkg.sv */
// package: register map, field layout and constants of the clock mode control block
package cgmc_pkg;

   // register indices (the bus address is the index itself)
   localparam logic [3:0] CGMC_IDX_CTRL1  = 4'h0;
   localparam logic [3:0] CGMC_IDX_STATUS = 4'h1;
   localparam logic [3:0] CGMC_IDX_ENV    = 4'h2;

   // control register one field positions
   localparam int CGMC_BIT_GAIN  = 7;
   localparam int CGMC_BIT_RANGE = 6;
   localparam int CGMC_BIT_EXT_REF_SOURCE_SEL  = 5;
   localparam int CGMC_BIT_MODEH = 4;
   localparam int CGMC_BIT_MODEL = 3;
   localparam int CGMC_BIT_KEEP  = 2;
   localparam int CGMC_BIT_CLOCK_LOSS_DETECT_OFF  = 1;

   // reset values
   localparam logic [7:0] CGMC_CTRL1_RST = 8'h00;

   // mode-change completion time and its cycle count at 200 MHz
   localparam int CGMC_CLK_MHZ        = 200;
   localparam int CGMC_MODE_SYNC_NS   = 20;
   localparam int CGMC_MODE_SYNC_CYC  = (CGMC_MODE_SYNC_NS * CGMC_CLK_MHZ + 999) / 1000;
   localparam logic [3:0] CGMC_SYNC_MAX = 4'(CGMC_MODE_SYNC_CYC);

   // loop prescale factors
   localparam logic [6:0] CGMC_PRESCALE_LOW  = 7'h40;
   localparam logic [6:0] CGMC_PRESCALE_HIGH = 7'h01;

   typedef enum logic [1:0] {
      CGMC_MODE_SELF   = 2'h0,
      CGMC_MODE_INT    = 2'h1,
      CGMC_MODE_BYPASS = 2'h2,
      CGMC_MODE_EXT    = 2'h3
   } cgmc_mode_e;

   typedef enum logic [2:0] {
      CGMC_ST_IDLE = 3'b001,
      CGMC_ST_SYNC = 3'b010,
      CGMC_ST_WAIT = 3'b100
   } cgmc_st_e;

   // register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cgmc_bus_s;

   // pin usage and oscillator control
   typedef struct packed {
      logic       pins_claimed;
      logic       in_is_clock;
      logic       in_is_osc;
      logic       out_is_osc;
      logic       osc_high_gain;
      logic       osc_run;
      logic       range_high;
      logic [6:0] prescale;
      logic       loss_detect_en;
   } cgmc_osc_s;

   // all state of the block
   typedef struct packed {
      logic       first_done;
      logic       first_mode_low;
      logic       osc_high_gain_sel;
      logic       range_sel;
      logic       ext_ref_source_sel;
      cgmc_mode_e clock_mode_sel;
      logic       osc_keep_in_off;
      logic       clock_loss_detect_off;
      cgmc_mode_e pend_mode;
      cgmc_st_e   st;
      logic [3:0] cnt;
      cgmc_mode_e clock_mode_status;
      logic [7:0] rdata;
      cgmc_osc_s  osc;
   } cgmc_state_s;

endpackage

/* cgmc_top.sv */
// clock generator mode control: control register one, pin claim and oscillator enables
//
// Summary of operation
// - first external-mode write claims input pin by source
// - first external-mode write claims output pin
// - first internal or self mode frees both pins
// - oscillator defaults to low-power after reset
// - gain bit: 0 low power, 1 high gain
// - gain, range, source bits are write-once
// - range 0 prescale 64, range 1 prescale 1
// - range matters only in external modes
// - source bit 0 external clock, 1 crystal
// - mode field bits 4:3 encode four modes
// - bypass waits until external reference clock ok is 1
// - off mode keeps mode field unchanged
// - mode write dropped while previous incomplete
// - first low mode blocks later high modes
// - keep-in-off ignored when gain and range set
// - keep-in-off clear: oscillator off, one exception
// - keep-in-off set: runs in high modes
// - loss detect off bit: 1 disables detection
// - mode status lags select through synchroniser
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
module cgmc_top
   import cgmc_pkg::*;
(
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // register port
   input  wire cgmc_pkg::cgmc_bus_s  bus,
   output      logic [7:0]           rdata,
   // environment
   input  wire logic                 ext_ref_clock_ok,
   input  wire logic                 ref_select_status,
   input  wire logic                 off_mode,
   input  wire logic                 enable_in,
   // oscillator and pin control
   output      cgmc_pkg::cgmc_osc_s  osc,
   output      logic [1:0]           clock_mode_status
);
   import cgmc_pkg::*;

   cgmc_state_s s_q;
   cgmc_state_s s_d;

   logic ctrl_wr;
   logic mode_ok;
   logic ext_mode;
   logic keep_ignored;

   assign ctrl_wr = bus.wr && (bus.addr == CGMC_IDX_CTRL1);

   always_comb begin
      s_d = s_q;
      ext_mode = s_q.clock_mode_sel[1];
      mode_ok = 1'b0;
      keep_ignored = s_q.osc_high_gain_sel && s_q.range_sel;
      if (ctrl_wr) begin
         if (!s_q.first_done) begin
            s_d.first_done = 1'b1;
            s_d.osc_high_gain_sel = bus.wdata[CGMC_BIT_GAIN];
            s_d.range_sel = bus.wdata[CGMC_BIT_RANGE];
            s_d.ext_ref_source_sel = bus.wdata[CGMC_BIT_EXT_REF_SOURCE_SEL];
            s_d.first_mode_low = !bus.wdata[CGMC_BIT_MODEH];
         end
         s_d.osc_keep_in_off = bus.wdata[CGMC_BIT_KEEP];
         s_d.clock_loss_detect_off = bus.wdata[CGMC_BIT_CLOCK_LOSS_DETECT_OFF];
         // drop while busy, and high modes when first write was low
         mode_ok = (s_q.st == CGMC_ST_IDLE)
            && !(s_q.first_done && s_q.first_mode_low && bus.wdata[CGMC_BIT_MODEH]);
         if (mode_ok) begin
            s_d.clock_mode_sel = cgmc_mode_e'(bus.wdata[CGMC_BIT_MODEH:CGMC_BIT_MODEL]);
            s_d.pend_mode = cgmc_mode_e'(bus.wdata[CGMC_BIT_MODEH:CGMC_BIT_MODEL]);
            s_d.st = CGMC_ST_SYNC;
            s_d.cnt = 4'h0;
         end
      end
      // mode change completes after a synchronising delay
      case (s_q.st)
         CGMC_ST_IDLE: begin
         end
         CGMC_ST_SYNC: begin
            if (s_q.cnt >= CGMC_SYNC_MAX - 4'h1) begin
               s_d.st = CGMC_ST_WAIT;
            end else begin
               s_d.cnt = s_q.cnt + 4'h1;
            end
         end
         CGMC_ST_WAIT: begin
            if (s_q.pend_mode != CGMC_MODE_BYPASS || ext_ref_clock_ok) begin
               s_d.clock_mode_status = s_q.pend_mode;
               s_d.st = CGMC_ST_IDLE;
            end
         end
         default: s_d.st = CGMC_ST_IDLE;
      endcase
      // read data, one cycle later
      s_d.rdata = 8'h00;
      if (bus.rd) begin
         case (bus.addr)
            CGMC_IDX_CTRL1: s_d.rdata = {s_q.osc_high_gain_sel, s_q.range_sel,
               s_q.ext_ref_source_sel, s_q.clock_mode_sel, s_q.osc_keep_in_off,
               s_q.clock_loss_detect_off, 1'b0};
            CGMC_IDX_STATUS: s_d.rdata = {s_q.clock_mode_status, ref_select_status,
               s_q.first_done, s_q.st != CGMC_ST_IDLE, 3'h0};
            CGMC_IDX_ENV: s_d.rdata = {5'h00, ext_ref_clock_ok, off_mode, enable_in};
            default: s_d.rdata = 8'h00;
         endcase
      end
      // pin claim is fixed by the first write
      s_d.osc.pins_claimed = s_d.first_done && !s_d.first_mode_low;
      s_d.osc.in_is_clock = s_d.osc.pins_claimed && !s_d.ext_ref_source_sel;
      s_d.osc.in_is_osc = s_d.osc.pins_claimed && s_d.ext_ref_source_sel;
      s_d.osc.out_is_osc = s_d.osc.pins_claimed;
      s_d.osc.osc_high_gain = s_d.osc_high_gain_sel;
      s_d.osc.range_high = s_d.range_sel && s_d.clock_mode_sel[1];
      s_d.osc.prescale = (s_d.osc.range_high) ? CGMC_PRESCALE_HIGH : CGMC_PRESCALE_LOW;
      s_d.osc.loss_detect_en = !s_d.clock_loss_detect_off;
      // oscillator run in and out of off mode
      if (!off_mode) begin
         s_d.osc.osc_run = s_d.osc.pins_claimed && ext_mode;
      end else if (s_q.osc_keep_in_off && !keep_ignored) begin
         s_d.osc.osc_run = ext_mode && ref_select_status;
      end else begin
         s_d.osc.osc_run = enable_in && (s_q.clock_mode_sel == CGMC_MODE_BYPASS)
            && ref_select_status;
      end
   end

   // mode field holds through off mode since only writes change it
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q <= '{first_done: 1'b0, first_mode_low: 1'b0, osc_high_gain_sel: 1'b0,
                  range_sel: 1'b0, ext_ref_source_sel: 1'b0,
                  clock_mode_sel: CGMC_MODE_SELF, osc_keep_in_off: 1'b0,
                  clock_loss_detect_off: 1'b0, pend_mode: CGMC_MODE_SELF,
                  st: CGMC_ST_IDLE, cnt: 4'h0, clock_mode_status: CGMC_MODE_SELF,
                  rdata: 8'h00,
                  osc: '{pins_claimed: 1'b0, in_is_clock: 1'b0, in_is_osc: 1'b0,
                         out_is_osc: 1'b0, osc_high_gain: 1'b0, osc_run: 1'b0,
                         range_high: 1'b0, prescale: CGMC_PRESCALE_LOW,
                         loss_detect_en: 1'b1}};
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign osc = s_q.osc;
   assign clock_mode_status = s_q.clock_mode_status;

   a_write_once_gain: assert property (@(posedge clk_sys) disable iff (rst)
      s_q.first_done |=> s_q.osc_high_gain_sel == $past(s_q.osc_high_gain_sel))
      else $error("gain bit changed after first write");

   a_first_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl_wr |=> s_q.first_done)
      else $error("first write flag not set");

   a_high_mode_block: assert property (@(posedge clk_sys) disable iff (rst)
      s_q.first_done && s_q.first_mode_low |-> !s_q.clock_mode_sel[1])
      else $error("high mode accepted after low first write");

   a_busy_drop: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl_wr && s_q.st != CGMC_ST_IDLE |=> $stable(s_q.clock_mode_sel))
      else $error("mode write taken while busy");

   a_bypass_wait: assert property (@(posedge clk_sys) disable iff (rst)
      s_q.st == CGMC_ST_WAIT && s_q.pend_mode == CGMC_MODE_BYPASS && !ext_ref_clock_ok
      |=> s_q.st == CGMC_ST_WAIT)
      else $error("bypass taken without reference");

   a_pins_free: assert property (@(posedge clk_sys) disable iff (rst)
      s_q.first_done && s_q.first_mode_low |=> !osc.in_is_clock && !osc.in_is_osc
      && !osc.out_is_osc)
      else $error("pins claimed in internal mode");

   a_prescale_sel: assert property (@(posedge clk_sys) disable iff (rst)
      osc.prescale == (osc.range_high ? CGMC_PRESCALE_HIGH : CGMC_PRESCALE_LOW))
      else $error("prescale wrong");

   a_loss_detect: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl_wr |=> osc.loss_detect_en == !$past(bus.wdata[CGMC_BIT_CLOCK_LOSS_DETECT_OFF]))
      else $error("loss detect enable wrong");

   a_keep_ignored: assert property (@(posedge clk_sys) disable iff (rst)
      off_mode && keep_ignored && !enable_in |=> !osc.osc_run)
      else $error("keep-in-off used with gain and range set");

   a_status_lag: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl_wr && mode_ok |=> s_q.st == CGMC_ST_SYNC ##1 $stable(clock_mode_status))
      else $error("mode status did not lag");

endmodule

/* cgmc_osc_model.sv */
// external clock source model: reference turns valid a while after the pin is claimed
`timescale 1ns/100ps
module cgmc_osc_model
   import cgmc_pkg::*;
#(
   parameter int START_CYC = 8
)
(
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rst,
   // pin control from the block, stall from the bench
   input  wire cgmc_pkg::cgmc_osc_s osc,
   input  wire logic                stall,
   // reference status back to the block
   output      logic                ext_ref_clock_ok,
   output      logic                ref_select_status
);
   import cgmc_pkg::*;
   logic [7:0] run_cnt_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         run_cnt_q         <= 8'h00;
         ext_ref_clock_ok  <= 1'b0;
         ref_select_status <= 1'b0;
      end else begin
         ref_select_status <= osc.pins_claimed & osc.in_is_osc;
         if (!osc.pins_claimed || stall) begin
            run_cnt_q        <= 8'h00;
            ext_ref_clock_ok <= 1'b0;
         end else if (run_cnt_q < 8'(START_CYC)) begin
            run_cnt_q <= run_cnt_q + 8'h01;
         end else begin
            ext_ref_clock_ok <= 1'b1;
         end
      end
   end
endmodule

/* cgmc_top_tb.sv */
// testbench for the clock mode control block with an external source model
`timescale 1ns/100ps
module cgmc_top_tb;
   import cgmc_pkg::*;
   logic       clk_sys;
   logic       rst;
   cgmc_bus_s  bus;
   logic [7:0] rdata;
   logic       ext_ref_clock_ok;
   logic       ref_select_status;
   logic       off_mode;
   logic       enable_in;
   logic       stall;
   cgmc_osc_s  osc;
   logic [1:0] clock_mode_status;
   logic [7:0] v;
   int         n_errors;
   int         n_checks;
   int         n_cyc;

   cgmc_top cgmc_top_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
      .ext_ref_clock_ok(ext_ref_clock_ok), .ref_select_status(ref_select_status),
      .off_mode(off_mode), .enable_in(enable_in), .osc(osc),
      .clock_mode_status(clock_mode_status));
   cgmc_osc_model cgmc_osc_model_inst (.clk_sys(clk_sys), .rst(rst), .osc(osc),
      .stall(stall), .ext_ref_clock_ok(ext_ref_clock_ok),
      .ref_select_status(ref_select_status));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      n_cyc = n_cyc + 1;
      if (n_cyc == 20000) begin
         n_errors = n_errors + 1;
         complete_run();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus.wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic wait_mode(input logic [1:0] m);
      for (int i = 0; i < 40 && clock_mode_status !== m; i++) begin
         @(posedge clk_sys);
         #1;
      end
      check({6'h00, clock_mode_status}, {6'h00, m});
   endtask

   task automatic do_reset();
      rst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic t_reset();
      do_reset();
      rd(4'h0, v);
      check(v, CGMC_CTRL1_RST);
      check({7'h00, osc.osc_high_gain}, 8'h00);
      check({1'b0, osc.prescale}, 8'h40);
      check({7'h00, osc.loss_detect_en}, 8'h01);
      check({7'h00, osc.pins_claimed}, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_ext();
      wr(4'h0, 8'hF8);
      check({4'h0, osc.pins_claimed, osc.in_is_osc, osc.in_is_clock, osc.out_is_osc},
         8'h0D);
      check({7'h00, osc.osc_high_gain}, 8'h01);
      check({1'b0, osc.prescale}, 8'h01);
      wait_mode(2'h3);
      wr(4'h0, 8'h1A);
      rd(4'h0, v);
      check(v, 8'hFA);
      check({7'h00, osc.loss_detect_en}, 8'h00);
      stall <= 1'b1;
      repeat (8) @(posedge clk_sys);
      wr(4'h0, 8'hF0);
      wr(4'h0, 8'hE8);
      rd(4'h0, v);
      check(v, 8'hF0);
      repeat (20) @(posedge clk_sys);
      #1 check({6'h00, clock_mode_status}, 8'h03);
      stall <= 1'b0;
      wait_mode(2'h2);
      off_mode <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(4'h0, v);
      check(v, 8'hF0);
      wr(4'h0, 8'hF4);
      repeat (3) @(posedge clk_sys);
      #1 check({7'h00, osc.osc_run}, 8'h00);
      off_mode <= 1'b0;
      $display("test external done");
   endtask

   task automatic t_off();
      do_reset();
      wr(4'h0, 8'h30);
      wait_mode(2'h2);
      off_mode <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 check({7'h00, osc.osc_run}, 8'h00);
      enable_in <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 check({7'h00, osc.osc_run}, 8'h01);
      enable_in <= 1'b0;
      wr(4'h0, 8'h34);
      repeat (3) @(posedge clk_sys);
      #1 check({7'h00, osc.osc_run}, 8'h01);
      off_mode <= 1'b0;
      $display("test off mode done");
   endtask

   task automatic t_int();
      do_reset();
      wr(4'h0, 8'h48);
      check({7'h00, osc.pins_claimed}, 8'h00);
      check({1'b0, osc.prescale}, 8'h40);
      wait_mode(2'h1);
      wr(4'h0, 8'h18);
      rd(4'h0, v);
      check(v, 8'h48);
      repeat (10) @(posedge clk_sys);
      #1 check({6'h00, clock_mode_status}, 8'h01);
      check({7'h00, osc.range_high}, 8'h00);
      rd(4'h1, v);
      check(v, 8'h50);
      $display("test internal done");
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      bus = '0;
      off_mode = 1'b0;
      enable_in = 1'b0;
      stall = 1'b0;
      n_errors = 0;
      n_checks = 0;
      n_cyc = 0;
      t_reset();
      t_ext();
      t_off();
      t_int();
      complete_run();
   end
endmodule
